// *** rtl/mie_consts.svh ***
`ifndef MIE_CONSTS_SVH
`define MIE_CONSTS_SVH
// Instruction word and program counter widths
`define MIE_IW 17
`define MIE_PCW 11
`define MIE_RST_PC 11'h000
// Instruction fields
`define MIE_OP_MSB 16
`define MIE_OP_LSB 11
`define MIE_BIT_MSB 10
`define MIE_BIT_LSB 8
// Data memory address that aliases the program counter low byte
`define MIE_PCL_ADDR 8'h02
`define MIE_LAST_PAGE 3'h7
// Decimal adjust constants
`define MIE_DAA_LO 8'h06
`define MIE_DAA_HI 8'h60
`define MIE_NIB_MAX 4'h9
// Register bus map (byte addresses)
`define MIE_AW 12
`define MIE_REG_CTRL 12'h000
`define MIE_REG_STATUS 12'h004
`define MIE_REG_WORKING 12'h008
`define MIE_REG_PC 12'h00c
`define MIE_REG_TABLE_HIGH_LATCH 12'h010
`define MIE_REG_WDT 12'h014
`define MIE_DMEM_WIN 2'h1
// Control and status bit positions
`define MIE_CTRL_RUN 0
`define MIE_CTRL_WAKE 1
`define MIE_ST_C 0
`define MIE_ST_AC 1
`define MIE_ST_Z 2
`define MIE_ST_OV 3
`define MIE_ST_TO 4
`define MIE_ST_PDF 5
`define MIE_ST_GIE 6
`define MIE_ST_HALT 7
`endif

// *** rtl/mie_pkg.sv ***
`include "mie_consts.svh"
package mie_pkg;
    typedef logic [`MIE_IW-1:0] mie_word_t;
    typedef logic [`MIE_PCW-1:0] mie_pc_t;
    typedef enum logic [1:0] {CORE_EXEC, CORE_DUMMY, CORE_TABLE} mie_state_t;
    typedef enum logic [5:0] {
        OP_IDLE, OP_COPY_FROM_MEM, OP_LOAD_IMM, OP_COPY_TO_MEM, OP_BIT_ZERO_FILL, OP_BIT_ONES_FILL,
        OP_GOTO, OP_SKIP_ZERO, OP_SKIP_ZERO_TO_WORKING, OP_SKIP_ZERO_BIT, OP_SKIP_NONZERO_BIT,
        OP_BUMP_SKIP, OP_DROP_SKIP, OP_BUMP_SKIP_TO_WORKING, OP_DROP_SKIP_TO_WORKING,
        OP_SUBROUTINE_ENTRY, OP_SUBROUTINE_EXIT, OP_SUBROUTINE_EXIT_LOAD, OP_INTERRUPT_EXIT,
        OP_LOOKUP_READ, OP_LOOKUP_READ_LAST_PAGE, OP_ZERO_FILL, OP_ONES_FILL, OP_WATCHDOG_KICK,
        OP_NIBBLE_EXCHANGE, OP_NIBBLE_EXCHANGE_TO_WORKING, OP_POWERDOWN, OP_SUM, OP_SUM_IMM,
        OP_SUM_TO_MEM, OP_ADD_WITH_CARRY, OP_SUM_CARRY_TO_MEM, OP_BITWISE_CONJ, OP_CONJ_IMM,
        OP_CONJ_TO_MEM, OP_INVERT, OP_INVERT_TO_WORKING, OP_DECIMAL_FIX
    } mie_op_t;
endpackage : mie_pkg

// *** rtl/mie_core.sv ***
// Operation
// - Copy memory or immediate into working register in one cycle, flags kept
// - Store working register into memory in one cycle, flags kept
// - Bit clear and bit set touch only the selected bit, no flags
// - Goto, call, both returns and interrupt return take two cycles, no flags
// - Call pushes program counter plus one, then loads target
// - Skips take one cycle, or two when the skip is taken
// - Zero tests on byte or bit; skip-zero-to-working also copies byte
// - Increment or decrement skips write back or load working, skip on zero
// - Any write of program counter low byte costs two cycles
// - Table reads fetch program word to high latch and memory in two cycles
// - Watchdog kick clears counter and power-down flag in one cycle; expiry flag cleared unless the counter overflows that cycle
// - Nibble exchange in place or into working register, no flags
// - Whole byte clear or set, no flags; idle does nothing in one cycle
// - Add with carry into working or memory, updating four arithmetic flags
// - Add memory or immediate into working, or into memory, four flags
// - AND into working or memory, only zero flag affected
// - Complement in place or into working, only zero flag affected
// - Decimal adjust working register, result written to memory
// - Decimal adjust adds six per nibble above nine or flagged; carry only
// - Power-down halts, keeps state, clears watchdog, sets power-down flag
// - Interrupt return restores program counter and sets global enable
// - Bit index selects bit 0 to 7 of a byte
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "mie_consts.svh"
module mie_core #(
    parameter int STACK_DEPTH = 8,
    parameter int PRESC_W = 4
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // Avalon-MM register slave
    input wire logic [`MIE_AW-1:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [3:0] BYTEENABLE,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    // Program memory
    output mie_pkg::mie_pc_t PM_ADDR,
    input wire mie_pkg::mie_word_t PM_DATA
);
    import mie_pkg::*;
    localparam int PCW = `MIE_PCW;
    localparam int SPW = $clog2(STACK_DEPTH);
    localparam int HW = `MIE_IW - 8;
    typedef struct packed {
        mie_pc_t pc;
        mie_pc_t pm_addr;
        mie_state_t st;
        logic [7:0] wreg;
        logic c;
        logic ac;
        logic z;
        logic ov;
        logic to;
        logic powerdown_flag;
        logic gie;
        logic halted;
        logic run;
        logic [HW-1:0] table_high_latch;
        logic [7:0] tbl_m;
        logic [7:0] wdt;
        logic [PRESC_W-1:0] presc;
        logic [SPW-1:0] sp;
        logic [STACK_DEPTH-1:0][PCW-1:0] stack;
        logic wait_n;
        logic [31:0] rdata;
    } mie_core_t;
    mie_core_t q;
    mie_core_t d;
    logic [7:0] dmem [0:255];
    logic dm_we;
    logic [7:0] dm_wa;
    logic [7:0] dm_wd;
    mie_op_t op;
    logic [7:0] m;
    logic [2:0] bsel;
    logic [7:0] mval;
    logic bus_wr;
    logic core_go;
    logic exec;
    function automatic logic [10:0] mie_add(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        mie_add = {(a[7] == b[7]) && (s[7] != a[7]), h[4], s[8], s[7:0]};
    endfunction : mie_add
    assign op = mie_op_t'(PM_DATA[`MIE_OP_MSB:`MIE_OP_LSB]);
    assign m = PM_DATA[7:0];
    assign bsel = PM_DATA[`MIE_BIT_MSB:`MIE_BIT_LSB];
    assign mval = (m == `MIE_PCL_ADDR) ? q.pc[7:0] : dmem[m];
    assign bus_wr = WRITE && !q.wait_n && BYTEENABLE[0];
    assign core_go = q.run && !q.halted && !bus_wr;
    assign exec = core_go && q.st == CORE_EXEC;
    always_comb
    begin
        logic wr_mem;
        logic [7:0] wv;
        logic skip;
        logic [10:0] sum;
        logic [7:0] opnd;
        logic lo_adj;
        logic hi_adj;
        logic [8:0] daa;
        wr_mem = 1'b0;
        wv = 8'h00;
        skip = 1'b0;
        opnd = (op == OP_SUM_IMM || op == OP_CONJ_IMM) ? m : mval;
        sum = mie_add(q.wreg, opnd, (op == OP_ADD_WITH_CARRY || op == OP_SUM_CARRY_TO_MEM) ? q.c : 1'b0);
        lo_adj = (q.wreg[3:0] > `MIE_NIB_MAX) || q.ac;
        hi_adj = (q.wreg[7:4] > `MIE_NIB_MAX) || q.c;
        daa = {1'b0, q.wreg} + {1'b0, hi_adj ? `MIE_DAA_HI : 8'h00} + {1'b0, lo_adj ? `MIE_DAA_LO : 8'h00};
        d = q;
        dm_we = 1'b0;
        dm_wa = m;
        dm_wd = 8'h00;
        d.wait_n = 1'b1;
        if ((READ || WRITE) && q.wait_n)
        begin
            d.wait_n = 1'b0;
            d.rdata = 32'h0;
            if (ADDRESS[`MIE_AW-1:10] == `MIE_DMEM_WIN)
                d.rdata = 32'(dmem[ADDRESS[9:2]]);
            else
            begin
                unique case (ADDRESS)
                    `MIE_REG_CTRL: d.rdata = 32'(q.run);
                    `MIE_REG_STATUS: d.rdata = 32'({q.halted, q.gie, q.powerdown_flag, q.to, q.ov, q.z, q.ac, q.c});
                    `MIE_REG_WORKING: d.rdata = 32'(q.wreg);
                    `MIE_REG_PC: d.rdata = 32'(q.pc);
                    `MIE_REG_TABLE_HIGH_LATCH: d.rdata = 32'(q.table_high_latch);
                    `MIE_REG_WDT: d.rdata = 32'(q.wdt);
                    default: d.rdata = 32'h0;
                endcase
            end
        end
        if (bus_wr)
        begin
            if (ADDRESS[`MIE_AW-1:10] == `MIE_DMEM_WIN)
            begin
                dm_we = 1'b1;
                dm_wa = ADDRESS[9:2];
                dm_wd = WRITEDATA[7:0];
            end
            else if (ADDRESS == `MIE_REG_CTRL)
            begin
                d.run = WRITEDATA[`MIE_CTRL_RUN];
                if (WRITEDATA[`MIE_CTRL_WAKE])
                    d.halted = 1'b0;
            end
            else if (ADDRESS == `MIE_REG_STATUS)
            begin
                d.c = WRITEDATA[`MIE_ST_C];
                d.ac = WRITEDATA[`MIE_ST_AC];
                d.z = WRITEDATA[`MIE_ST_Z];
                d.ov = WRITEDATA[`MIE_ST_OV];
                d.gie = WRITEDATA[`MIE_ST_GIE];
            end
            else if (ADDRESS == `MIE_REG_WORKING)
                d.wreg = WRITEDATA[7:0];
        end
        if (core_go)
        begin
            d.presc = q.presc + PRESC_W'(1);
            if (&q.presc)
            begin
                d.wdt = q.wdt + 8'h01;
                if (&q.wdt)
                    d.to = 1'b1;
            end
            unique case (q.st)
                CORE_DUMMY:
                    d.st = CORE_EXEC;
                CORE_TABLE:
                begin
                    d.table_high_latch = PM_DATA[`MIE_IW-1:8];
                    d.st = CORE_EXEC;
                    if (q.tbl_m == `MIE_PCL_ADDR)
                        d.pc = {q.pc[PCW-1:8], PM_DATA[7:0]};
                    else
                    begin
                        dm_we = 1'b1;
                        dm_wa = q.tbl_m;
                        dm_wd = PM_DATA[7:0];
                    end
                end
                CORE_EXEC:
                begin
                    d.pc = q.pc + PCW'(1);
                    case (op)
                        OP_COPY_FROM_MEM: d.wreg = mval;
                        OP_LOAD_IMM: d.wreg = m;
                        OP_COPY_TO_MEM: begin wr_mem = 1'b1; wv = q.wreg; end
                        OP_BIT_ZERO_FILL: begin wr_mem = 1'b1; wv = mval & ~(8'h01 << bsel); end
                        OP_BIT_ONES_FILL: begin wr_mem = 1'b1; wv = mval | (8'h01 << bsel); end
                        OP_GOTO: begin d.pc = PM_DATA[PCW-1:0]; d.st = CORE_DUMMY; end
                        OP_SKIP_ZERO: skip = (mval == 8'h00);
                        OP_SKIP_ZERO_TO_WORKING: begin d.wreg = mval; skip = (mval == 8'h00); end
                        OP_SKIP_ZERO_BIT: skip = !mval[bsel];
                        OP_SKIP_NONZERO_BIT: skip = mval[bsel];
                        OP_BUMP_SKIP: begin wr_mem = 1'b1; wv = mval + 8'h01; skip = (wv == 8'h00); end
                        OP_DROP_SKIP: begin wr_mem = 1'b1; wv = mval - 8'h01; skip = (wv == 8'h00); end
                        OP_BUMP_SKIP_TO_WORKING: begin d.wreg = mval + 8'h01; skip = (d.wreg == 8'h00); end
                        OP_DROP_SKIP_TO_WORKING: begin d.wreg = mval - 8'h01; skip = (d.wreg == 8'h00); end
                        OP_SUBROUTINE_ENTRY:
                        begin
                            d.stack[q.sp] = q.pc + PCW'(1);
                            d.sp = q.sp + SPW'(1);
                            d.pc = PM_DATA[PCW-1:0];
                            d.st = CORE_DUMMY;
                        end
                        OP_SUBROUTINE_EXIT, OP_SUBROUTINE_EXIT_LOAD, OP_INTERRUPT_EXIT:
                        begin
                            d.sp = q.sp - SPW'(1);
                            d.pc = q.stack[q.sp - SPW'(1)];
                            d.st = CORE_DUMMY;
                            if (op == OP_SUBROUTINE_EXIT_LOAD)
                                d.wreg = m;
                            if (op == OP_INTERRUPT_EXIT)
                                d.gie = 1'b1;
                        end
                        OP_LOOKUP_READ, OP_LOOKUP_READ_LAST_PAGE:
                        begin
                            d.tbl_m = m;
                            d.st = CORE_TABLE;
                            d.pm_addr = {op == OP_LOOKUP_READ ? q.pc[PCW-1:8] : `MIE_LAST_PAGE, q.wreg};
                        end
                        OP_ZERO_FILL: begin wr_mem = 1'b1; wv = 8'h00; end
                        OP_ONES_FILL: begin wr_mem = 1'b1; wv = 8'hff; end
                        OP_WATCHDOG_KICK:
                        begin
                            d.wdt = 8'h00;
                            d.presc = '0;
                            d.to = (&q.presc) && (&q.wdt);
                            d.powerdown_flag = 1'b0;
                        end
                        OP_NIBBLE_EXCHANGE: begin wr_mem = 1'b1; wv = {mval[3:0], mval[7:4]}; end
                        OP_NIBBLE_EXCHANGE_TO_WORKING: d.wreg = {mval[3:0], mval[7:4]};
                        OP_POWERDOWN:
                        begin
                            d.halted = 1'b1;
                            d.wdt = 8'h00;
                            d.presc = '0;
                            d.to = (&q.presc) && (&q.wdt);
                            d.powerdown_flag = 1'b1;
                        end
                        OP_SUM, OP_SUM_IMM, OP_ADD_WITH_CARRY, OP_SUM_TO_MEM, OP_SUM_CARRY_TO_MEM:
                        begin
                            {d.ov, d.ac, d.c} = sum[10:8];
                            d.z = (sum[7:0] == 8'h00);
                            if (op == OP_SUM_TO_MEM || op == OP_SUM_CARRY_TO_MEM)
                            begin
                                wr_mem = 1'b1;
                                wv = sum[7:0];
                            end
                            else
                                d.wreg = sum[7:0];
                        end
                        OP_BITWISE_CONJ, OP_CONJ_IMM: begin d.wreg = q.wreg & opnd; d.z = (d.wreg == 8'h00); end
                        OP_CONJ_TO_MEM: begin wr_mem = 1'b1; wv = q.wreg & mval; d.z = (wv == 8'h00); end
                        OP_INVERT: begin wr_mem = 1'b1; wv = ~mval; d.z = (wv == 8'h00); end
                        OP_INVERT_TO_WORKING: begin d.wreg = ~mval; d.z = (d.wreg == 8'h00); end
                        OP_DECIMAL_FIX: begin wr_mem = 1'b1; wv = daa[7:0]; d.c = hi_adj | daa[8]; end
                        default: ;
                    endcase
                    // Taken skip steps over next word
                    if (skip)
                    begin
                        d.pc = q.pc + PCW'(2);
                        d.st = CORE_DUMMY;
                    end
                    if (wr_mem)
                    begin
                        if (m == `MIE_PCL_ADDR)
                        begin
                            d.pc = {q.pc[PCW-1:8], wv};
                            d.st = CORE_DUMMY;
                        end
                        else
                        begin
                            dm_we = 1'b1;
                            dm_wd = wv;
                        end
                    end
                end
                default: d.st = CORE_EXEC;
            endcase
            if (d.st != CORE_TABLE)
                d.pm_addr = d.pc;
        end
    end
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            q <= '0;
            q.pc <= `MIE_RST_PC;
            q.pm_addr <= `MIE_RST_PC;
            q.st <= CORE_EXEC;
            q.wait_n <= 1'b1;
        end
        else
            q <= d;
    end

    always_ff @(posedge CLOCK)
    begin
        if (dm_we)
            dmem[dm_wa] <= dm_wd;
    end

    assign READDATA = q.rdata;
    assign WAITREQUEST = q.wait_n;
    assign PM_ADDR = q.pm_addr;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    flags_kept_load_a: assert property ((exec && (op == OP_COPY_FROM_MEM || op == OP_LOAD_IMM)) |=>
        ($stable({q.c, q.ac, q.z, q.ov}) && q.wreg == $past(op == OP_LOAD_IMM ? m : mval)))
        else $error("load changed flags or value");
    store_mem_a: assert property ((exec && op == OP_COPY_TO_MEM && m != `MIE_PCL_ADDR) |=>
        (dmem[$past(m)] == $past(q.wreg) && q.st == CORE_EXEC))
        else $error("store wrong");
    bit_clear_a: assert property ((exec && op == OP_BIT_ZERO_FILL && m != `MIE_PCL_ADDR) |=>
        (dmem[$past(m)] == ($past(mval) & ~(8'h01 << $past(bsel)))))
        else $error("bit clear wrong");
    goto_two_a: assert property ((exec && op == OP_GOTO) |=>
        (q.st == CORE_DUMMY && q.pc == $past(PM_DATA[PCW-1:0])) ##1 (q.st == CORE_EXEC || $past(!core_go)))
        else $error("goto timing wrong");
    call_push_a: assert property ((exec && op == OP_SUBROUTINE_ENTRY) |=>
        (q.stack[$past(q.sp)] == $past(q.pc) + PCW'(1) && q.sp == $past(q.sp) + SPW'(1)))
        else $error("call push wrong");
    skip_taken_a: assert property ((exec && op == OP_SKIP_ZERO && mval == 8'h00) |=>
        (q.st == CORE_DUMMY && q.pc == $past(q.pc) + PCW'(2)))
        else $error("skip not taken");
    skip_not_a: assert property ((exec && op == OP_SKIP_NONZERO_BIT && !mval[bsel]) |=>
        (q.st == CORE_EXEC && q.pc == $past(q.pc) + PCW'(1)))
        else $error("skip wrongly taken");
    pcl_write_a: assert property ((exec && op == OP_ZERO_FILL && m == `MIE_PCL_ADDR) |=>
        (q.st == CORE_DUMMY && q.pc[7:0] == 8'h00))
        else $error("low counter write not two cycles");
    table_two_a: assert property ((exec && op == OP_LOOKUP_READ_LAST_PAGE) |=>
        (q.st == CORE_TABLE && q.pm_addr[PCW-1:8] == `MIE_LAST_PAGE))
        else $error("table read wrong");
    kick_clear_a: assert property ((exec && op == OP_WATCHDOG_KICK) |=>
        (q.to == $past(&q.presc && &q.wdt) && !q.powerdown_flag && q.wdt == 8'h00))
        else $error("kick failed");
    powerdown_a: assert property ((exec && op == OP_POWERDOWN) |=>
        (q.halted && q.powerdown_flag && q.to == $past(&q.presc && &q.wdt) && $stable(q.wreg)))
        else $error("power-down wrong");
    daa_carry_a: assert property ((exec && op == OP_DECIMAL_FIX) |=>
        ($stable({q.ac, q.z, q.ov, q.wreg})))
        else $error("decimal adjust touched other flags");
    interrupt_exit_op_gie_a: assert property ((exec && op == OP_INTERRUPT_EXIT) |=> q.gie)
        else $error("interrupt enable not set");
    bus_answer_a: assert property (((READ || WRITE) && WAITREQUEST) |=> !WAITREQUEST ##1 WAITREQUEST)
        else $error("bus answer timing wrong");

    skip_cov_c: cover property (exec && op == OP_BUMP_SKIP && mval == 8'hff);
    call_cov_c: cover property (exec && op == OP_SUBROUTINE_ENTRY);
    table_cov_c: cover property (core_go && q.st == CORE_TABLE);
    halt_cov_c: cover property (exec && op == OP_POWERDOWN);
endmodule : mie_core
`default_nettype wire

// *** dv/mie_prog_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module mie_prog_mem (
    // Program fetch
    input wire mie_pkg::mie_pc_t PM_ADDR,
    output mie_pkg::mie_word_t PM_DATA
);
    import mie_pkg::*;
    mie_word_t rom [0:2047];
    // Unloaded words read as idle so prefetch never sees unknowns
    initial
    begin
        for (int i = 0; i < 2048; i++)
            rom[i] = '0;
    end
    // Asynchronous read, answered in the same cycle
    assign PM_DATA = rom[PM_ADDR];
endmodule : mie_prog_mem
`default_nettype wire

// *** dv/mie_core_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module mie_core_tb;
    import mie_pkg::*;
    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    logic [11:0] ADDRESS = 12'h000;
    logic READ = 1'b0;
    logic WRITE = 1'b0;
    logic [31:0] WRITEDATA = 32'h0;
    logic [3:0] BYTEENABLE = 4'h1;
    logic [31:0] READDATA;
    logic WAITREQUEST;
    mie_pc_t PM_ADDR;
    mie_word_t PM_DATA;
    int n_errors = 0;
    int n_compared = 0;

    mie_core DUT (.CLOCK(CLOCK), .RST(RST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
        .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
        .WAITREQUEST(WAITREQUEST), .PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA));
    mie_prog_mem PMEM (.PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA));

    always #20 CLOCK = ~CLOCK;

    function automatic mie_word_t ins(input mie_op_t op, input logic [10:0] f);
        return {op, f};
    endfunction : ins

    task automatic finish_test();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            n_errors++;
        end
    endtask : check

    // Avalon cycle held until waitrequest is sampled low
    task automatic bus(input logic rd, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] q);
        @(posedge CLOCK);
        READ <= rd;
        WRITE <= !rd;
        ADDRESS <= a;
        WRITEDATA <= wd;
        @(posedge CLOCK);
        while (WAITREQUEST !== 1'b0)
            @(posedge CLOCK);
        q = READDATA;
        READ <= 1'b0;
        WRITE <= 1'b0;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b0, a, {24'h0, d}, q);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b1, a, 32'h0, q);
        check(q, exp);
    endtask : rd_chk

    task automatic test_reset();
        rd_chk(12'h004, 32'h0);
        rd_chk(12'h00c, 32'h0);
        rd_chk(12'h100, 32'h0);
    endtask : test_reset

    // Arithmetic, bit, skip, call and power-down sequence
    task automatic test_program();
        PMEM.rom[0] = ins(OP_LOAD_IMM, 11'h038);
        PMEM.rom[1] = ins(OP_COPY_TO_MEM, 11'h020);
        PMEM.rom[2] = ins(OP_IDLE, 11'h000);
        PMEM.rom[3] = ins(OP_SUM, 11'h021);
        PMEM.rom[4] = ins(OP_DECIMAL_FIX, 11'h022);
        PMEM.rom[5] = ins(OP_BIT_ONES_FILL, 11'h723);
        PMEM.rom[6] = ins(OP_NIBBLE_EXCHANGE, 11'h024);
        PMEM.rom[7] = ins(OP_INVERT_TO_WORKING, 11'h024);
        PMEM.rom[8] = ins(OP_CONJ_TO_MEM, 11'h025);
        PMEM.rom[9] = ins(OP_BUMP_SKIP, 11'h026);
        PMEM.rom[10] = ins(OP_LOAD_IMM, 11'h011);
        PMEM.rom[11] = ins(OP_SUBROUTINE_ENTRY, 11'h00f);
        PMEM.rom[12] = ins(OP_POWERDOWN, 11'h000);
        PMEM.rom[13] = ins(OP_WATCHDOG_KICK, 11'h000);
        PMEM.rom[14] = ins(OP_GOTO, 11'h00e);
        PMEM.rom[15] = ins(OP_SUBROUTINE_EXIT, 11'h000);
        wr(12'h484, 8'h49);
        wr(12'h48c, 8'h00);
        wr(12'h490, 8'h5a);
        wr(12'h494, 8'h0f);
        wr(12'h498, 8'hff);
        wr(12'h000, 8'h01);
        repeat (60) @(posedge CLOCK);
        rd_chk(12'h480, 32'h38);
        rd_chk(12'h488, 32'h87);
        rd_chk(12'h48c, 32'h80);
        rd_chk(12'h490, 32'ha5);
        rd_chk(12'h494, 32'h0a);
        rd_chk(12'h498, 32'h00);
        rd_chk(12'h008, 32'h5a);
        rd_chk(12'h004, 32'haa);
    endtask : test_program

    // Wake, watchdog kick, read-only program counter
    task automatic test_wake();
        wr(12'h000, 8'h03);
        repeat (20) @(posedge CLOCK);
        wr(12'h000, 8'h00);
        rd_chk(12'h004, 32'h0a);
        wr(12'h00c, 8'h33);
        rd_chk(12'h00c, 32'h00e);
    endtask : test_wake

    // Mid-run reset, carry chain, skips, table read, interrupt return, low counter write
    task automatic test_restart();
        @(posedge CLOCK);
        RST <= 1'b1;
        repeat (3) @(posedge CLOCK);
        RST <= 1'b0;
        rd_chk(12'h00c, 32'h0);
        rd_chk(12'h004, 32'h0);
        PMEM.rom[11'h000] = ins(OP_GOTO, 11'h101);
        PMEM.rom[11'h100] = ins(OP_GOTO, 11'h100);
        PMEM.rom[11'h101] = ins(OP_LOAD_IMM, 11'h099);
        PMEM.rom[11'h102] = ins(OP_ADD_WITH_CARRY, 11'h032);
        PMEM.rom[11'h103] = ins(OP_DECIMAL_FIX, 11'h033);
        PMEM.rom[11'h104] = ins(OP_SKIP_ZERO, 11'h030);
        PMEM.rom[11'h105] = ins(OP_LOAD_IMM, 11'h011);
        PMEM.rom[11'h106] = ins(OP_SKIP_NONZERO_BIT, 11'h431);
        PMEM.rom[11'h107] = ins(OP_BIT_ZERO_FILL, 11'h031);
        PMEM.rom[11'h108] = ins(OP_LOOKUP_READ_LAST_PAGE, 11'h034);
        PMEM.rom[11'h109] = ins(OP_SUBROUTINE_ENTRY, 11'h10c);
        PMEM.rom[11'h10a] = ins(OP_ZERO_FILL, 11'h002);
        PMEM.rom[11'h10c] = ins(OP_INTERRUPT_EXIT, 11'h000);
        PMEM.rom[11'h733] = 17'h15ac3;
        wr(12'h4c0, 8'h00);
        wr(12'h4c4, 8'h0f);
        wr(12'h4c8, 8'h99);
        wr(12'h004, 8'h01);
        wr(12'h000, 8'h01);
        repeat (40) @(posedge CLOCK);
        rd_chk(12'h008, 32'h33);
        rd_chk(12'h4cc, 32'h99);
        rd_chk(12'h4c4, 32'h0e);
        rd_chk(12'h4d0, 32'hc3);
        rd_chk(12'h010, 32'h15a);
        rd_chk(12'h004, 32'h4b);
        rd_chk(12'h00c, 32'h100);
    endtask : test_restart

    initial
    begin
        repeat (5) @(posedge CLOCK);
        RST <= 1'b0;
        test_reset();
        test_program();
        test_wake();
        test_restart();
        finish_test();
    end

    initial
    begin
        #400000;
        n_errors++;
        finish_test();
    end
endmodule : mie_core_tb
`default_nettype wire
